// ---- inc/dmtcu_pkg.sv ----
// Constants, field layouts and carrier types of the timer/counter unit.
// Assumes one system clock; pins arrive unsynchronised.
package dmtcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned TMR_N  = 5;
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned PIN_N  = 10;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned FLAG_N = 8;

  // Timer index
  localparam int unsigned T_AUX_A  = 0;
  localparam int unsigned T_CORE1  = 1;
  localparam int unsigned T_AUX_B  = 2;
  localparam int unsigned T_AUX2   = 3;
  localparam int unsigned T_CORE2  = 4;

  // Pin index inside the pin vector
  localparam int unsigned P_AUX_A_IN  = 0;
  localparam int unsigned P_AUX_A_DIR = 1;
  localparam int unsigned P_CORE1_IN  = 2;
  localparam int unsigned P_CORE1_DIR = 3;
  localparam int unsigned P_AUX_B_IN  = 4;
  localparam int unsigned P_AUX_B_DIR = 5;
  localparam int unsigned P_AUX2_IN   = 6;
  localparam int unsigned P_CORE2_IN  = 7;
  localparam int unsigned P_CORE2_DIR = 8;
  localparam int unsigned P_CAP_IN    = 9;

  localparam int unsigned TMR_IN_PIN  [TMR_N] = '{0, 2, 4, 6, 7};
  localparam int unsigned TMR_DIR_PIN [TMR_N] = '{1, 3, 5, 0, 8};
  localparam bit          TMR_HAS_DIR [TMR_N] = '{1, 1, 1, 0, 1};

  // Finest step, as a power of two of system clock cycles
  localparam logic [3:0] FIRST_BASE_SHIFT  = 4'h2;
  localparam logic [3:0] SECOND_BASE_SHIFT = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Register index
  localparam logic [ADDR_W-1:0] A_CTRL0  = 4'h0;
  localparam logic [ADDR_W-1:0] A_CAPCTL = 4'h5;
  localparam logic [ADDR_W-1:0] A_VAL0   = 4'h6;
  localparam logic [ADDR_W-1:0] A_CAPTURE_RELOAD_REGISTER = 4'hB;
  localparam logic [ADDR_W-1:0] A_FLAGS  = 4'hC;

  // Timer control fields
  localparam int unsigned CTL_PS_LSB    = 0;
  localparam int unsigned CTL_MODE_LSB  = 3;
  localparam int unsigned CTL_RUN       = 5;
  localparam int unsigned CTL_DIR_SW    = 6;
  localparam int unsigned CTL_DIR_EXT   = 7;
  localparam int unsigned CTL_EDGE_LSB  = 8;
  localparam int unsigned CTL_ROLE_LSB  = 10;
  localparam int unsigned CTL_TOUT_EN   = 10;
  localparam int unsigned CTL_RLD_CAPR  = 11;
  localparam int unsigned CTL_RLD_TLR   = 12;
  localparam int unsigned CTL_RLD_TLF   = 13;
  localparam int unsigned CTL_GATE_LVL  = 14;

  // Capture control fields
  localparam int unsigned CAP_EDGE_LSB = 0;
  localparam int unsigned CAP_CLR      = 2;
  localparam int unsigned CAP_CORE_IN  = 3;
  localparam int unsigned CAP_CORE_DIR = 4;
  localparam int unsigned CAP_EN       = 5;

  // Flag bits: 0..4 timer wrap, then captures
  localparam int unsigned FLG_CAP_A  = 5;
  localparam int unsigned FLG_CAP_B  = 6;
  localparam int unsigned FLG_CAPTURE_RELOAD_REGISTER = 7;

  localparam logic [TMR_W-1:0] REG_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_QUAD
  } dmtcu_mode_t;

  typedef enum logic [1:0] {
    ROLE_NORMAL, ROLE_CHAINED, ROLE_CAPTURE, ROLE_RELOAD
  } dmtcu_role_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [TMR_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } dmtcu_bus_t;

  // Edge select: bit 0 rising, bit 1 falling
  function automatic logic dmtcu_edge_hit(input logic [1:0] sel,
                                          input logic       rise,
                                          input logic       fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction : dmtcu_edge_hit

  // One count step; top bit flags wrap past either end
  function automatic logic [16:0] dmtcu_step(input logic [15:0] v,
                                             input logic        en,
                                             input logic        dn);
    logic [16:0] r;
    r = {1'b0, v};
    if (en) begin
      if (dn) r = {(v == 16'h0000), v - 16'h0001};
      else    r = {(v == 16'hFFFF), v + 16'h0001};
    end
    return r;
  endfunction : dmtcu_step

endpackage : dmtcu_pkg

// ---- design/dmtcu_top.sv ----
// Five-timer unit in two modules with capture/reload register.
// Assumes pins are asynchronous and a one-cycle strobe register port.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps

module dmtcu_top
  import dmtcu_pkg::*;
#(
  parameter int unsigned PRESC_W = 12
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  // Register port
  input  wire dmtcu_bus_t        i_bus,
  output logic [TMR_W-1:0]       o_rd_data,
  // Timer pins
  input  wire logic [PIN_N-1:0]  i_pins,
  output logic                   o_first_core_toggle_output,
  output logic                   o_second_core_toggle_output,
  output logic                   o_second_core_wrap_pulse,
  output logic [FLAG_N-1:0]      o_req_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Longest prescale is 2^(2+7) cycles
  if (PRESC_W < 10) begin : g_presc_chk
    $error("PRESC_W must be at least 10");
  end

  typedef struct packed {
    logic [2:0][PIN_N-1:0]       sync;
    logic [PIN_N-1:0]            pin;
    logic [PRESC_W-1:0]          presc;
    logic [TMR_N-1:0][TMR_W-1:0] tval;
    logic [TMR_N:0][TMR_W-1:0]   ctrl;
    logic [TMR_W-1:0]            capture_reload_register;
    logic [FLAG_N-1:0]           flags;
    logic                        tl1;
    logic                        tl2;
    logic                        wrap2;
    logic                        out1;
    logic                        out2;
    logic [TMR_W-1:0]            rd_data;
  } dmtcu_state_t;

  dmtcu_state_t     s_reg;
  dmtcu_state_t     s_next;
  logic [TMR_N-1:0] step_c;
  logic [TMR_N-1:0] down_c;
  logic [TMR_N-1:0] wrap_c;
  logic [TMR_N-1:0] aux_cap_c;
  logic             cap_trig_c;

  // Prescaler tap: true once every 2^sh cycles
  function automatic logic tick_hit(input logic [PRESC_W-1:0] cnt,
                                    input logic [3:0]         sh);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((32'd1 << sh) - 32'd1);
    return (cnt & m) == '0;
  endfunction : tick_hit

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [TMR_W-1:0]  c;
    dmtcu_mode_t       md;
    dmtcu_role_t       rl;
    logic [PIN_N-1:0]  agree;
    logic [PIN_N-1:0]  edg;
    logic [PIN_N-1:0]  rise;
    logic [PIN_N-1:0]  fall;
    logic [3:0]        sh;
    logic [16:0]       r;
    logic              tl1_r;
    logic              tl1_f;
    logic              tl2_r;
    logic              tl2_f;
    logic              trig;
    c      = '0;
    md     = MODE_TIMER;
    rl     = ROLE_NORMAL;
    sh     = '0;
    r      = '0;
    trig   = 1'b0;
    agree  = '0;
    edg    = '0;
    rise   = '0;
    fall   = '0;
    tl1_r  = 1'b0;
    tl1_f  = 1'b0;
    tl2_r  = 1'b0;
    tl2_f  = 1'b0;
    s_next = s_reg;
    step_c    = '0;
    down_c    = '0;
    wrap_c    = '0;
    aux_cap_c = '0;

    // Three stages; a change counts once stages two and three agree
    s_next.sync[0] = i_pins;
    s_next.sync[1] = s_reg.sync[0];
    s_next.sync[2] = s_reg.sync[1];
    agree          = ~(s_reg.sync[1] ^ s_reg.sync[2]);
    s_next.pin     = (agree & s_reg.sync[2]) | (~agree & s_reg.pin);
    edg            = s_next.pin ^ s_reg.pin;
    rise           = edg & s_next.pin;
    fall           = edg & ~s_next.pin;
    s_next.presc   = s_reg.presc + 1'b1;

    // five timers, own step and direction
    for (int i = 0; i < TMR_N; i++) begin
      c  = s_reg.ctrl[i];
      md = dmtcu_mode_t'(c[CTL_MODE_LSB +: 2]);
      sh = ((i < 3) ? FIRST_BASE_SHIFT : SECOND_BASE_SHIFT)
           + {1'b0, c[CTL_PS_LSB +: 3]};
      unique case (md)
        MODE_TIMER:   step_c[i] = tick_hit(s_reg.presc, sh);
        MODE_GATED:   step_c[i] = tick_hit(s_reg.presc, sh)
                        & (s_next.pin[TMR_IN_PIN[i]] == c[CTL_GATE_LVL]);
        MODE_COUNTER: step_c[i] = dmtcu_edge_hit(c[CTL_EDGE_LSB +: 2],
                        rise[TMR_IN_PIN[i]], fall[TMR_IN_PIN[i]]);
        MODE_QUAD:    step_c[i] = (i < 3)
                        && (edg[TMR_IN_PIN[i]] || edg[TMR_DIR_PIN[i]]);
      endcase
      step_c[i] = step_c[i] & c[CTL_RUN];
      // software direction, optionally flipped by pin
      // second aux never sees a direction pin
      down_c[i] = c[CTL_DIR_SW] ^ (c[CTL_DIR_EXT] & TMR_HAS_DIR[i]
                  & s_next.pin[TMR_DIR_PIN[i]]);
      if (md == MODE_QUAD && i < 3) begin
        down_c[i] = ~(s_next.pin[TMR_IN_PIN[i]]
                      ^ s_reg.pin[TMR_DIR_PIN[i]]);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core timers first: their latches clock the auxiliaries
    r = dmtcu_step(s_reg.tval[T_CORE1], step_c[T_CORE1], down_c[T_CORE1]);
    wrap_c[T_CORE1]        = r[16];
    s_next.tval[T_CORE1]   = r[15:0];
    if (wrap_c[T_CORE1]) s_next.tl1 = ~s_reg.tl1;
    tl1_r = s_next.tl1 & ~s_reg.tl1;
    tl1_f = ~s_next.tl1 & s_reg.tl1;

    r = dmtcu_step(s_reg.tval[T_CORE2], step_c[T_CORE2], down_c[T_CORE2]);
    wrap_c[T_CORE2]        = r[16];
    s_next.tval[T_CORE2]   = r[15:0];
    if (wrap_c[T_CORE2]) s_next.tl2 = ~s_reg.tl2;
    tl2_r = s_next.tl2 & ~s_reg.tl2;
    tl2_f = ~s_next.tl2 & s_reg.tl2;
    if (wrap_c[T_CORE2] && s_reg.ctrl[T_CORE2][CTL_RLD_CAPR]) begin
      s_next.tval[T_CORE2] = s_reg.capture_reload_register;
    end
    s_next.wrap2 = wrap_c[T_CORE2];

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary timers; aux B reload wins a tie with aux A
    for (int j = 0; j < TMR_N; j++) begin
      if (j != T_CORE1 && j != T_CORE2) begin
        c  = s_reg.ctrl[j];
        rl = dmtcu_role_t'(c[CTL_ROLE_LSB +: 2]);
        trig = dmtcu_edge_hit(c[CTL_EDGE_LSB +: 2],
                 rise[TMR_IN_PIN[j]], fall[TMR_IN_PIN[j]]);
        unique case (rl)
          ROLE_NORMAL: begin
            r = dmtcu_step(s_reg.tval[j], step_c[j], down_c[j]);
          end
          // clocked by own module's core latch
          ROLE_CHAINED: begin
            r = dmtcu_step(s_reg.tval[j], c[CTL_RUN] & ((j < 3)
                  ? dmtcu_edge_hit(c[CTL_EDGE_LSB +: 2], tl1_r, tl1_f)
                  : dmtcu_edge_hit(c[CTL_EDGE_LSB +: 2], tl2_r, tl2_f)),
                  down_c[j]);
          end
          // stopped; aux A/B latch first core on own pin, second aux only holds
          ROLE_CAPTURE: begin
            r = {1'b0, s_reg.tval[j]};
            if (j < 3 && trig) begin
              r            = {1'b0, s_reg.tval[T_CORE1]};
              aux_cap_c[j] = 1'b1;
            end
          end
          // stopped; aux A/B reload first core on pin or first latch edge, second aux only holds
          ROLE_RELOAD: begin
            r = {1'b0, s_reg.tval[j]};
            if (j < 3 && (trig || (c[CTL_RLD_TLR] && tl1_r)
                              || (c[CTL_RLD_TLF] && tl1_f))) begin
              s_next.tval[T_CORE1] = s_reg.tval[j];
            end
          end
        endcase
        wrap_c[j]      = r[16];
        s_next.tval[j] = r[15:0];
      end
    end

    ////////////////////////////////////////////////////////////////////////
    c = s_reg.ctrl[TMR_N];
    // capture pin edge; first core pin edges
    cap_trig_c = c[CAP_EN] & (dmtcu_edge_hit(c[CAP_EDGE_LSB +: 2],
                   rise[P_CAP_IN], fall[P_CAP_IN])
                 | (c[CAP_CORE_IN] & edg[P_CORE1_IN])
                 | (c[CAP_CORE_DIR] & edg[P_CORE1_DIR]));
    if (cap_trig_c) begin
      s_next.capture_reload_register = s_reg.tval[T_AUX2];
      if (c[CAP_CLR]) s_next.tval[T_AUX2] = REG_RST;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software access; software value writes override hardware
    if (i_bus.wr) begin
      if (i_bus.addr <= A_CAPCTL) begin
        s_next.ctrl[i_bus.addr] = i_bus.wdata;
      end else if (i_bus.addr < A_CAPTURE_RELOAD_REGISTER) begin
        s_next.tval[3'(i_bus.addr - A_VAL0)] = i_bus.wdata;
      end else if (i_bus.addr == A_CAPTURE_RELOAD_REGISTER) begin
        s_next.capture_reload_register = i_bus.wdata;
      end else if (i_bus.addr == A_FLAGS) begin
        s_next.flags = s_reg.flags & ~i_bus.wdata[FLAG_N-1:0];
      end
    end
    // sticky flags; a set beats a same-cycle clear
    s_next.flags = s_next.flags | {cap_trig_c, aux_cap_c[T_AUX_B],
                   aux_cap_c[T_AUX_A], wrap_c};

    s_next.rd_data = REG_RST;
    if (i_bus.rd) begin
      if (i_bus.addr <= A_CAPCTL) begin
        s_next.rd_data = s_reg.ctrl[i_bus.addr];
      end else if (i_bus.addr < A_CAPTURE_RELOAD_REGISTER) begin
        s_next.rd_data = s_reg.tval[3'(i_bus.addr - A_VAL0)];
      end else if (i_bus.addr == A_CAPTURE_RELOAD_REGISTER) begin
        s_next.rd_data = s_reg.capture_reload_register;
      end else if (i_bus.addr == A_FLAGS) begin
        s_next.rd_data = {8'h00, s_reg.flags};
      end
    end

    s_next.out1 = s_next.tl1 & s_next.ctrl[T_CORE1][CTL_TOUT_EN];
    s_next.out2 = s_next.tl2 & s_next.ctrl[T_CORE2][CTL_TOUT_EN];
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rd_data                   = s_reg.rd_data;
  assign o_first_core_toggle_output  = s_reg.out1;
  assign o_second_core_toggle_output = s_reg.out2;
  assign o_second_core_wrap_pulse    = s_reg.wrap2;
  assign o_req_flags                 = s_reg.flags;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  tick_resol_a:
    assert property ((s_reg.ctrl[T_CORE1][CTL_MODE_LSB +: 2] == MODE_TIMER)
                     && step_c[T_CORE1] |-> s_reg.presc[1:0] == 2'b00)
    else $error("core step off the four-cycle grid");
  gate_level_a:
    assert property ((s_reg.ctrl[T_AUX_A][CTL_MODE_LSB +: 2] == MODE_GATED)
                     && step_c[T_AUX_A] |-> s_next.pin[P_AUX_A_IN]
                     == s_reg.ctrl[T_AUX_A][CTL_GATE_LVL])
    else $error("gated step with gate inactive");
  latch_flip_a:
    assert property (wrap_c[T_CORE1] |=> s_reg.tl1 != $past(s_reg.tl1)
                     ##1 o_first_core_toggle_output
                     == (s_reg.tl1 & s_reg.ctrl[T_CORE1][CTL_TOUT_EN]))
    else $error("first toggle latch missed a wrap");
  cap_stop_a:
    assert property ((s_reg.ctrl[T_AUX_B][CTL_ROLE_LSB +: 2] == ROLE_CAPTURE)
                     && !i_bus.wr && !aux_cap_c[T_AUX_B]
                     |=> $stable(s_reg.tval[T_AUX_B]))
    else $error("capture-role timer kept counting");
  cap_value_a:
    assert property (aux_cap_c[T_AUX_B] && !i_bus.wr
                     |=> s_reg.tval[T_AUX_B] == $past(s_reg.tval[T_CORE1])
                     && s_reg.flags[FLG_CAP_B])
    else $error("aux capture value or flag wrong");
  capture_reload_register_cap_a:
    assert property (cap_trig_c && !i_bus.wr
                     |=> s_reg.capture_reload_register == $past(s_reg.tval[T_AUX2]))
    else $error("capture register missed aux value");
  aux_clear_a:
    assert property (cap_trig_c && s_reg.ctrl[TMR_N][CAP_CLR] && !i_bus.wr
                     |=> s_reg.tval[T_AUX2] == 16'h0000)
    else $error("second aux not cleared after capture");
  wrap_reload_a:
    assert property (wrap_c[T_CORE2] && s_reg.ctrl[T_CORE2][CTL_RLD_CAPR]
                     && !i_bus.wr |=> s_reg.tval[T_CORE2]
                     == $past(s_reg.capture_reload_register) && o_second_core_wrap_pulse)
    else $error("second core wrap reload or pulse wrong");
  flag_set_a:
    assert property (wrap_c[T_CORE2] |=> s_reg.flags[T_CORE2]
                     ##1 (s_reg.flags[T_CORE2] || $past(i_bus.wr)))
    else $error("wrap flag not held");

  quad_down_c:
    cover property ((s_reg.ctrl[T_CORE1][CTL_MODE_LSB +: 2] == MODE_QUAD)
                    && step_c[T_CORE1] && down_c[T_CORE1]);
  pwm_reload_c:
    cover property (wrap_c[T_CORE1]
                    && s_reg.ctrl[T_AUX_A][CTL_ROLE_LSB +: 2] == ROLE_RELOAD
                    && s_reg.ctrl[T_AUX_B][CTL_ROLE_LSB +: 2] == ROLE_RELOAD);
  capture_reload_register_clr_c:
    cover property (cap_trig_c && s_reg.ctrl[TMR_N][CAP_CLR]);

endmodule : dmtcu_top

// ---- testbench/dmtcu_pins_model.sv ----
// Pin-side model: sensor phases and plain level pins for the timer unit.
// Assumes the bench moves levels and step requests right after clock edges.
`timescale 1ns/100ps
module dmtcu_pins_model
  import dmtcu_pkg::*;
(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  // Bench commands
  input  wire logic [PIN_N-1:0] i_lvl,
  input  wire logic             i_quad_on,
  input  wire logic             i_step,
  input  wire logic             i_back,
  // Pins toward the unit
  output logic      [PIN_N-1:0] o_pins
);
  logic [1:0] pos_reg;

  ////////////////////////////////////////
  // Sensor position, one phase moves per step so no glitch pairs
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos_reg <= 2'h0;
    end else if (i_step) begin
      pos_reg <= i_back ? pos_reg - 2'h1 : pos_reg + 2'h1;
    end
  end

  // Phases ride on the core count and direction pins
  always_comb begin
    o_pins = i_lvl;
    if (i_quad_on) begin
      o_pins[P_CORE1_IN]  = pos_reg[0] ^ pos_reg[1];
      o_pins[P_CORE1_DIR] = pos_reg[1];
    end
  end
endmodule : dmtcu_pins_model

// ---- testbench/dual_module_timer_counter_unit_bench.sv ----
// Self-checking bench for the five-timer unit.
// Assumes the pin model sits on the pins and the bench drives the bus.
`timescale 1ns/100ps
module dual_module_timer_counter_unit_bench;
  import dmtcu_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  dmtcu_bus_t       bus = '0;
  logic [PIN_N-1:0] lvl = '0;
  logic             quad_on = 1'b0;
  logic             step = 1'b0;
  logic             back = 1'b0;
  logic [PIN_N-1:0] pins;
  logic [TMR_W-1:0] rdat;
  logic [FLAG_N-1:0] flags;
  logic             tgl1, tgl2, wrp2;
  int               errors = 0;
  int               checks_done = 0;

  always #4 clk = ~clk;

  dmtcu_pins_model pm (.i_ref_clk(clk), .i_arst_n(rst_n), .i_lvl(lvl),
    .i_quad_on(quad_on), .i_step(step), .i_back(back), .o_pins(pins));
  dmtcu_top #(.PRESC_W(12)) dut (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_bus(bus), .o_rd_data(rdat), .i_pins(pins),
    .o_first_core_toggle_output(tgl1), .o_second_core_toggle_output(tgl2),
    .o_second_core_wrap_pulse(wrp2), .o_req_flags(flags));

  ////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdat;
  endtask : rd
  task automatic chk_rd(input string nm, input logic [3:0] a,
                        input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(nm, v, exp);
  endtask : chk_rd
  // Count change over exactly 40 cycles
  task automatic delta(input logic [3:0] a, output logic [15:0] d);
    logic [15:0] x, y;
    rd(a, x);
    repeat (38) @(posedge clk);
    rd(a, y);
    d = y - x;
  endtask : delta
  // Pins pass a sync chain, so give them time to land
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    lvl[i] <= v;
    repeat (6) @(posedge clk);
  endtask : pin
  task automatic wait_sig(input int w, input logic v, output int n);
    n = 0;
    #1;
    while ((w ? wrp2 : tgl1) !== v) begin
      @(posedge clk);
      #1 n++;
      if (n > 300) begin
        errors++;
        summarize;
      end
    end
  endtask : wait_sig

  ////////////////////////////////////////
  task automatic s_reset;
    for (int a = 0; a < 16; a++) chk_rd("reset", 4'(a), 16'h0000);
    wr(4'hD, 16'h1234);
    chk_rd("unmapped", 4'hD, 16'h0000);
    for (int a = 6; a < 11; a++) begin
      wr(4'(a), 16'hFFFF);
      chk_rd("width", 4'(a), 16'hFFFF);
      wr(4'(a), 16'h0000);
    end
  endtask : s_reset
  task automatic s_timer;
    logic [15:0] d;
    wr(4'h0, 16'h0020);
    delta(A_VAL0, d);
    check("ps0 step", d, 16'h000A);
    wr(4'h0, 16'h0021);
    delta(A_VAL0, d);
    check("ps1 step", d, 16'h0005);
    wr(4'h0, 16'h0060);
    delta(A_VAL0, d);
    check("down", d, 16'hFFF6);
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h0020);
    delta(4'hA, d);
    check("second step", d, 16'h0014);
    wr(4'h4, 16'h0000);
    pin(0, 1'b1);
    wr(4'h3, 16'h00E0);
    delta(4'h9, d);
    check("aux2 dir", d, 16'hFFEC);
    wr(4'h3, 16'h0000);
  endtask : s_timer
  task automatic s_gate;
    logic [15:0] d;
    pin(0, 1'b0);
    wr(4'h0, 16'h4028);
    delta(A_VAL0, d);
    check("gate shut", d, 16'h0000);
    pin(0, 1'b1);
    delta(A_VAL0, d);
    check("gate open", d, 16'h000A);
    wr(4'h0, 16'h0000);
    pin(0, 1'b0);
  endtask : s_gate
  task automatic s_count;
    wr(4'hA, 16'h0000);
    wr(4'h4, 16'h0130);
    repeat (5) begin
      pin(7, 1'b1);
      pin(7, 1'b0);
    end
    chk_rd("count up", 4'hA, 16'h0005);
    pin(8, 1'b1);
    wr(4'h4, 16'h01B0);
    repeat (3) begin
      pin(7, 1'b1);
      pin(7, 1'b0);
    end
    chk_rd("pin down", 4'hA, 16'h0002);
    wr(4'h4, 16'h0000);
    pin(8, 1'b0);
  endtask : s_count
  task automatic s_quad;
    wr(4'h1, 16'h0038);
    quad_on <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      step <= 1'b1;
      back <= (i > 7);
      @(posedge clk);
      step <= 1'b0;
      repeat (6) @(posedge clk);
    end
    chk_rd("position", 4'h7, 16'h0005);
    wr(4'h1, 16'h0000);
    quad_on <= 1'b0;
  endtask : s_quad
  task automatic s_wrap;
    wr(A_FLAGS, 16'h00FF);
    wr(A_VAL0, 16'h0000);
    wr(4'h0, 16'h0720);
    wr(4'h7, 16'hFFFE);
    wr(4'h1, 16'h0420);
    repeat (20) @(posedge clk);
    #1 check("latch out", {15'h0, tgl1}, 16'h0001);
    wr(4'h1, 16'h0000);
    chk_rd("chained", A_VAL0, 16'h0001);
    chk_rd("wrap flag", A_FLAGS, 16'h0002);
    wr(A_FLAGS, 16'h0002);
    chk_rd("flag clear", A_FLAGS, 16'h0000);
    wr(4'h8, 16'h0011);
    wr(4'h7, 16'hABCD);
    wr(4'h2, 16'h0920);
    pin(4, 1'b1);
    chk_rd("capture", 4'h8, 16'hABCD);
    repeat (40) @(posedge clk);
    chk_rd("held", 4'h8, 16'hABCD);
    chk_rd("cap flag", A_FLAGS, 16'h0040);
    pin(4, 1'b0);
  endtask : s_wrap
  task automatic s_pwm;
    int n, hi, lo;
    wr(4'h9, 16'h0000);
    wr(4'h3, 16'h0720);
    wr(A_VAL0, 16'hFFF0);
    wr(4'h0, 16'h2C00);
    wr(4'h8, 16'hFFF8);
    wr(4'h2, 16'h1C00);
    wr(4'h7, 16'hFFFE);
    wr(4'h1, 16'h0420);
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, hi);
    wait_sig(0, 1'b1, lo);
    check("pwm high", 16'(hi), 16'h0020);
    check("pwm low", 16'(lo), 16'h0040);
    wr(4'h1, 16'h0000);
    chk_rd("reload src", A_VAL0, 16'hFFF0);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0000);
    chk_rd("no cross chain", 4'h9, 16'h0000);
    wr(4'h3, 16'h0000);
  endtask : s_pwm
  task automatic s_cap2;
    wr(A_FLAGS, 16'h00FF);
    wr(4'h9, 16'h1234);
    wr(A_CAPCTL, 16'h0025);
    pin(9, 1'b1);
    chk_rd("capture_reload_register", A_CAPTURE_RELOAD_REGISTER, 16'h1234);
    chk_rd("aux2 clear", 4'h9, 16'h0000);
    check("flag port", {8'h00, flags}, 16'h0080);
    wr(4'h9, 16'h0055);
    pin(9, 1'b0);
    chk_rd("no fall", A_CAPTURE_RELOAD_REGISTER, 16'h1234);
    wr(A_CAPCTL, 16'h0028);
    pin(2, 1'b1);
    chk_rd("count trig", A_CAPTURE_RELOAD_REGISTER, 16'h0055);
    wr(4'h9, 16'h0066);
    wr(A_CAPCTL, 16'h0030);
    pin(3, 1'b1);
    chk_rd("dir trig", A_CAPTURE_RELOAD_REGISTER, 16'h0066);
    wr(A_CAPCTL, 16'h0000);
  endtask : s_cap2
  task automatic s_core2;
    int n;
    logic [15:0] v;
    wr(A_FLAGS, 16'h00FF);
    wr(4'h9, 16'h0000);
    wr(4'h3, 16'h0720);
    wr(4'hA, 16'hFFFC);
    wr(4'h4, 16'h0C20);
    wait_sig(1, 1'b1, n);
    @(posedge clk);
    #1 check("pulse len", {15'h0, wrp2}, 16'h0000);
    check("latch2", {15'h0, tgl2}, 16'h0001);
    wr(4'h4, 16'h0000);
    rd(4'hA, v);
    check("reload2", {15'h0, (v - 16'h0066) < 16'h0008}, 16'h0001);
    chk_rd("aux2 chain", 4'h9, 16'h0001);
    chk_rd("wrap2 flag", A_FLAGS, 16'h0010);
  endtask : s_core2

  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_reset;
    s_timer;
    s_gate;
    s_count;
    s_quad;
    s_wrap;
    s_pwm;
    s_cap2;
    s_core2;
    summarize;
  end
endmodule : dual_module_timer_counter_unit_bench
